// ### core/tifc_pkg.sv
// Package: offsets, field positions and reset values of the trace filter
package tifc_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] TIFC_OFF_TAG = 12'h040;
  localparam logic [11:0] TIFC_OFF_MAIN = 12'h080;
  localparam logic [11:0] TIFC_OFF_RANGE = 12'h084;
  localparam logic [11:0] TIFC_OFF_SS = 12'h088;
  localparam logic [11:0] TIFC_OFF_ENABLE = 12'h0c0;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TIFC_TAG_W = 7;
  localparam int TIFC_S3_BIT = 19;
  localparam int TIFC_S0_BIT = 16;
  localparam int TIFC_ERR_BIT = 11;
  localparam int TIFC_RST_BIT = 10;
  localparam int TIFC_SS_BIT = 9;
  localparam int TIFC_TYPE_BIT = 7;
  localparam int TIFC_EXCL_LSB = 16;
  localparam int TIFC_STOP_LSB = 16;
  localparam int TIFC_EN_BIT = 0;
  localparam int TIFC_DEN_BIT = 1;
  // Writable masks (reserved bits read zero)
  localparam logic [31:0] TIFC_MAIN_MASK = 32'h0009_0c8f;
  localparam logic [31:0] TIFC_RANGE_MASK = 32'h000f_000f;
  localparam logic [31:0] TIFC_SS_MASK = 32'h00ff_00ff;
  localparam logic [31:0] TIFC_EN_MASK = 32'h0000_0003;
  // Reset value, response codes and exception levels
  localparam logic [31:0] TIFC_RST_VAL = 32'h0000_0000;
  localparam logic [1:0] TIFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TIFC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] TIFC_EL0 = 2'h0;
  localparam logic [1:0] TIFC_EL3 = 2'h3;
endpackage : tifc_pkg

// ### core/tifc_startstop.sv
// Start/stop state holder driven by single address comparator matches
`timescale 1ns/1ps
`default_nettype none
module tifc_startstop #(
  parameter int NUM_SAC = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selections and matches
  input wire logic [NUM_SAC-1:0] start_sel,
  input wire logic [NUM_SAC-1:0] stop_sel,
  input wire logic [NUM_SAC-1:0] sac_match,
  // State
  output logic started
);
  logic next_started;
  logic hit_start;
  logic hit_stop;

  // Stop wins a simultaneous start so trace never leaks past a stop point
  always_comb begin
    hit_start = |(start_sel & sac_match);
    hit_stop = |(stop_sel & sac_match);
    next_started = started;
    if (hit_stop) begin
      next_started = 1'b0;
    end else if (hit_start) begin
      next_started = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      started <= 1'b0;
    end else begin
      started <= next_started;
    end
  end

  // Assertions
  stop_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hit_stop |=> !started) else $error("stop match did not stop");
  start_sets_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hit_start && !hit_stop |=> started)
    else $error("start match did not start");
endmodule : tifc_startstop
`default_nettype wire

// ### core/tifc_top.sv
// Trace stream tag and instruction view filter configuration block
// Operation
// - Instruction-only tracing uses the full 7-bit tag unchanged.
// - With data trace, instruction tag is upper six bits then 0.
// - With data trace, data tag is upper six bits then 1.
// - Secure level 3 disable bit suppresses the view at level 3.
// - Secure level 0 disable bit suppresses the view at level 0.
// - Force-error bit traces system error exceptions, except when a reset exception comes in the same cycle.
// - Force-reset bit always traces reset exceptions.
// - Status bit reads one when started, zero when stopped.
// - Type bit picks single resource 0-15 or pair 0-7.
// - Exclude bits per range comparator remove matching instructions.
// - Include bits per range; none set means everything included.
// - Selected stop comparator match enters stopped state.
// - Selected start comparator match enters started state, except when a stop match comes in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module tifc_top #(
  parameter int NUM_ARC = 4,
  parameter int NUM_SAC = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor trace inputs
  input wire logic [1:0] exc_level,
  input wire logic secure_state,
  input wire logic [15:0] single_resource,
  input wire logic [7:0] pair_resource,
  input wire logic [NUM_ARC-1:0] arc_match,
  input wire logic [NUM_SAC-1:0] sac_match,
  input wire logic is_syserr_exc,
  input wire logic is_reset_exc,
  input wire logic prev_traced,
  // Trace bus tags and filter result
  output logic [tifc_pkg::TIFC_TAG_W-1:0] instr_stream_tag,
  output logic [tifc_pkg::TIFC_TAG_W-1:0] data_stream_tag,
  output logic instruction_view_filter,
  output logic instr_trace
);
  import tifc_pkg::*;

  initial begin
    if (NUM_ARC < 1 || NUM_ARC > 4) $error("NUM_ARC must be 1..4");
    if (NUM_SAC < 1 || NUM_SAC > 8) $error("NUM_SAC must be 1..8");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [TIFC_TAG_W-1:0] stream_tag_value, next_stream_tag_value;
  logic [31:0] instr_view_main_ctrl, next_instr_view_main_ctrl;
  logic [31:0] instr_view_range_ctrl, next_instr_view_range_ctrl;
  logic [31:0] instr_view_startstop_ctrl, next_instr_view_startstop_ctrl;
  logic [1:0] enable_ctrl, next_enable_ctrl;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid_q, next_bvalid_q;
  logic [1:0] bresp_q, next_bresp_q;
  logic rvalid_q, next_rvalid_q;
  logic [1:0] rresp_q, next_rresp_q;
  logic [31:0] rdata_q, next_rdata_q;
  logic startstop_state;
  logic unit_on, data_on;

  assign unit_on = enable_ctrl[TIFC_EN_BIT];
  assign data_on = enable_ctrl[TIFC_DEN_BIT];

  // Byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb,
      input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : merge

  // Known register offset
  function automatic logic mapped(input logic [11:0] a);
    return a == TIFC_OFF_TAG || a == TIFC_OFF_MAIN ||
      a == TIFC_OFF_RANGE || a == TIFC_OFF_SS || a == TIFC_OFF_ENABLE;
  endfunction : mapped

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic do_write;
  logic [3:0] arc_mask_l;
  logic [7:0] sac_mask_l;
  logic [31:0] range_mask, ss_mask;
  assign s_axi_awready = !aw_held && !bvalid_q;
  assign s_axi_wready = !w_held && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign arc_mask_l = 4'((1 << NUM_ARC) - 1);
  assign sac_mask_l = 8'((1 << NUM_SAC) - 1);
  assign range_mask = TIFC_RANGE_MASK & {12'h000, arc_mask_l, 12'h000,
    arc_mask_l};
  assign ss_mask = TIFC_SS_MASK & {8'h00, sac_mask_l, 8'h00, sac_mask_l};

  // Address and data are caught in either order; response once both held
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid_q = bvalid_q;
    next_bresp_q = bresp_q;
    next_stream_tag_value = stream_tag_value;
    next_instr_view_main_ctrl = instr_view_main_ctrl;
    next_instr_view_range_ctrl = instr_view_range_ctrl;
    next_instr_view_startstop_ctrl = instr_view_startstop_ctrl;
    next_enable_ctrl = enable_ctrl;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid_q = 1'b0;
    end
    if (aw_held && w_held) begin
      do_write = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid_q = 1'b1;
      next_bresp_q = mapped(aw_addr) ? TIFC_RESP_OKAY : TIFC_RESP_SLVERR;
      unique case (aw_addr)
        TIFC_OFF_TAG: begin
          next_stream_tag_value = TIFC_TAG_W'(merge({25'h0,
            stream_tag_value}, w_data, w_strb, 32'h0000_007f));
        end
        TIFC_OFF_MAIN: begin
          next_instr_view_main_ctrl = merge(instr_view_main_ctrl, w_data,
            w_strb, TIFC_MAIN_MASK);
        end
        // Selections are frozen while tracing, as the far side must honour
        TIFC_OFF_RANGE: begin
          if (!unit_on) begin
            next_instr_view_range_ctrl = merge(instr_view_range_ctrl,
              w_data, w_strb, range_mask);
          end
        end
        TIFC_OFF_SS: begin
          if (!unit_on) begin
            next_instr_view_startstop_ctrl = merge(
              instr_view_startstop_ctrl, w_data, w_strb, ss_mask);
          end
        end
        TIFC_OFF_ENABLE: begin
          next_enable_ctrl = 2'(merge({30'h0, enable_ctrl}, w_data, w_strb,
            TIFC_EN_MASK));
        end
        default: begin
        end
      endcase
    end
  end

  // Read path; status bit is live start/stop state
  always_comb begin
    next_rvalid_q = rvalid_q;
    next_rresp_q = rresp_q;
    next_rdata_q = rdata_q;
    if (rvalid_q && s_axi_rready) begin
      next_rvalid_q = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid_q = 1'b1;
      next_rresp_q = mapped(s_axi_araddr) ? TIFC_RESP_OKAY
        : TIFC_RESP_SLVERR;
      unique case (s_axi_araddr)
        TIFC_OFF_TAG: next_rdata_q = {25'h0, stream_tag_value};
        TIFC_OFF_MAIN: begin
          next_rdata_q = instr_view_main_ctrl;
          next_rdata_q[TIFC_SS_BIT] = startstop_state;
        end
        TIFC_OFF_RANGE: next_rdata_q = instr_view_range_ctrl;
        TIFC_OFF_SS: next_rdata_q = instr_view_startstop_ctrl;
        TIFC_OFF_ENABLE: next_rdata_q = {30'h0, enable_ctrl};
        default: next_rdata_q = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= TIFC_RST_VAL;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= TIFC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= TIFC_RESP_OKAY;
      rdata_q <= TIFC_RST_VAL;
      stream_tag_value <= 7'h00;
      instr_view_main_ctrl <= TIFC_RST_VAL;
      instr_view_range_ctrl <= TIFC_RST_VAL;
      instr_view_startstop_ctrl <= TIFC_RST_VAL;
      enable_ctrl <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid_q;
      bresp_q <= next_bresp_q;
      rvalid_q <= next_rvalid_q;
      rresp_q <= next_rresp_q;
      rdata_q <= next_rdata_q;
      stream_tag_value <= next_stream_tag_value;
      instr_view_main_ctrl <= next_instr_view_main_ctrl;
      instr_view_range_ctrl <= next_instr_view_range_ctrl;
      instr_view_startstop_ctrl <= next_instr_view_startstop_ctrl;
      enable_ctrl <= next_enable_ctrl;
    end
  end

  // ****************************************************************
  // Start/stop logic
  // ****************************************************************
  tifc_startstop #(.NUM_SAC(NUM_SAC)) u_ss (
    .aclk(aclk),
    .aresetn(aresetn),
    .start_sel(instr_view_startstop_ctrl[NUM_SAC-1:0]),
    .stop_sel(instr_view_startstop_ctrl[TIFC_STOP_LSB +: NUM_SAC]),
    .sac_match(sac_match),
    .started(startstop_state)
  );

  // ****************************************************************
  // Filter and tags
  // ****************************************************************
  logic event_on, incl_hit, excl_hit, level_off, next_view, next_trace;
  logic [NUM_ARC-1:0] incl_sel, excl_sel;
  logic [TIFC_TAG_W-1:0] next_itag, next_dtag;
  assign incl_sel = instr_view_range_ctrl[NUM_ARC-1:0];
  assign excl_sel = instr_view_range_ctrl[TIFC_EXCL_LSB +: NUM_ARC];

  // Tags are registered so the trace bus sees a stable value
  always_comb begin
    if (instr_view_main_ctrl[TIFC_TYPE_BIT]) begin
      event_on = pair_resource[instr_view_main_ctrl[2:0]];
    end else begin
      event_on = single_resource[instr_view_main_ctrl[3:0]];
    end
    incl_hit = (incl_sel == '0) || |(incl_sel & arc_match);
    excl_hit = |(excl_sel & arc_match);
    level_off = secure_state && (
      (exc_level == TIFC_EL3 && instr_view_main_ctrl[TIFC_S3_BIT]) ||
      (exc_level == TIFC_EL0 && instr_view_main_ctrl[TIFC_S0_BIT]));
    next_view = event_on && startstop_state && incl_hit && !excl_hit &&
      !level_off;
    next_trace = next_view;
    if (is_syserr_exc) begin
      next_trace = instr_view_main_ctrl[TIFC_ERR_BIT] || prev_traced;
    end
    if (is_reset_exc) begin
      next_trace = instr_view_main_ctrl[TIFC_RST_BIT] || prev_traced;
    end
    if (data_on) begin
      next_itag = {stream_tag_value[6:1], 1'b0};
      next_dtag = {stream_tag_value[6:1], 1'b1};
    end else begin
      next_itag = stream_tag_value;
      next_dtag = 7'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_stream_tag <= 7'h00;
      data_stream_tag <= 7'h00;
      instruction_view_filter <= 1'b0;
      instr_trace <= 1'b0;
    end else begin
      instr_stream_tag <= next_itag;
      data_stream_tag <= next_dtag;
      instruction_view_filter <= next_view;
      instr_trace <= next_trace;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  itag_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !data_on |=> instr_stream_tag == $past(stream_tag_value))
    else $error("instruction tag not full value");
  itag_even_a: assert property (@(posedge aclk) disable iff (!aresetn)
    data_on |=> instr_stream_tag == {$past(stream_tag_value[6:1]), 1'b0})
    else $error("instruction tag not even");
  dtag_odd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    data_on |=> data_stream_tag == (instr_stream_tag | 7'h01))
    else $error("data tag not odd pair");
  s3_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    secure_state && exc_level == TIFC_EL3 && instr_view_main_ctrl[19]
    |=> !instruction_view_filter) else $error("level 3 not off");
  s0_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    secure_state && exc_level == TIFC_EL0 && instr_view_main_ctrl[16]
    |=> !instruction_view_filter) else $error("level 0 not off");
  err_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_syserr_exc && !is_reset_exc && instr_view_main_ctrl[11]
    |=> instr_trace) else $error("error exception not traced");
  rst_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_reset_exc && instr_view_main_ctrl[10] |=> instr_trace)
    else $error("reset exception not traced");
  excl_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(excl_sel & arc_match) |=> !instruction_view_filter)
    else $error("excluded range traced");
  stop_view_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !startstop_state |=> !instruction_view_filter)
    else $error("view while stopped");
  range_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unit_on && $stable(unit_on) |=> $stable(instr_view_range_ctrl))
    else $error("range changed while enabled");
endmodule : tifc_top
`default_nettype wire

// ### tb/tifc_sink_model.sv
// Trace bus sink model: records the tag of each traced instruction item
`timescale 1ns/1ps
`default_nettype none
module tifc_sink_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trace bus side
  input wire logic [tifc_pkg::TIFC_TAG_W-1:0] instr_stream_tag,
  input wire logic instr_trace,
  // Observations for the bench
  output logic [15:0] traced_count,
  output logic [tifc_pkg::TIFC_TAG_W-1:0] last_tag
);
  import tifc_pkg::*;
  // Tag is sampled with the trace flag, both leave the block registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      traced_count <= 16'h0000;
      last_tag <= 7'h00;
    end else if (instr_trace) begin
      traced_count <= traced_count + 16'h0001;
      last_tag <= instr_stream_tag;
    end
  end
endmodule : tifc_sink_model
`default_nettype wire

// ### tb/tifc_top_tb.sv
// Self-checking bench for the trace tag and instruction view block
`timescale 1ns/1ps
`default_nettype none
module tifc_top_tb;
  import tifc_pkg::*;
  // ******************************
  // Signals
  // ******************************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] exc_level = '0;
  logic secure_state = 1'h0, is_syserr_exc = 1'h0;
  logic is_reset_exc = 1'h0, prev_traced = 1'h0;
  logic [15:0] single_resource = '0;
  logic [7:0] pair_resource = '0;
  logic [3:0] arc_match = '0;
  logic [7:0] sac_match = '0;
  logic [6:0] instr_stream_tag, data_stream_tag, tr_tag, tg, itag;
  logic instruction_view_filter, instr_trace, started_exp;
  logic [15:0] tr_count, pmask;
  logic [31:0] r_main, r_rng, wd;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  logic [31:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] pq[$], pm[$];
  logic port_go = 1'h0;
  logic [11:0] offs[5] = '{TIFC_OFF_TAG, TIFC_OFF_MAIN, TIFC_OFF_RANGE,
                           TIFC_OFF_SS, TIFC_OFF_ENABLE};
  logic [31:0] msk[5] = '{32'h0000_007f, TIFC_MAIN_MASK, TIFC_RANGE_MASK,
                          TIFC_SS_MASK, TIFC_EN_MASK};
  logic [7:0] ss_in[5] = '{8'h01, 8'h04, 8'h03, 8'h02, 8'h01};
  logic ss_st[5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  always #5 aclk = ~aclk;
  // ******************************
  // Device and trace sink
  // ******************************
  tifc_top #(.NUM_ARC(4), .NUM_SAC(8)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .exc_level, .secure_state,
    .single_resource, .pair_resource, .arc_match, .sac_match,
    .is_syserr_exc, .is_reset_exc, .prev_traced, .instr_stream_tag,
    .data_stream_tag, .instruction_view_filter, .instr_trace);
  tifc_sink_model sink (.aclk, .aresetn, .instr_stream_tag, .instr_trace,
    .traced_count(tr_count), .last_tag(tr_tag));
  // ******************************
  // Checking
  // ******************************
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Bus answers are judged at the handshake edge, pre-update values
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      cmp("rdata", rq.pop_front(), s_axi_rdata);
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      cmp("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
  end

  // Port snapshot on the falling edge, when registered outputs settled
  always @(negedge aclk) begin
    if (port_go) begin
      port_go = 1'h0;
      pmask = pm.pop_front();
      cmp("ports", {16'h0, pq.pop_front() & pmask},
          {16'h0, {instr_stream_tag, data_stream_tag,
          instruction_view_filter, instr_trace} & pmask});
    end
  end
  // ******************************
  // Bus and stimulus tasks
  // ******************************
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] resp);
    bq.push_back(resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [11:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask : axr

  task automatic pchk(input logic [15:0] exp, input logic [15:0] m);
    pq.push_back(exp);
    pm.push_back(m);
    @(posedge aclk);
    port_go = 1'h1;
  endtask : pchk

  // One comparator match pulse, then time for the state to settle
  task automatic ssp(input logic [7:0] m);
    @(posedge aclk);
    sac_match <= m;
    @(posedge aclk);
    sac_match <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask : ssp

  // Random processor item; expected view and trace come from the config
  task automatic fstep();
    logic [1:0] el;
    logic sec, se, re, pv, ev, inc, exc, dis, v, t;
    logic [15:0] sg;
    logic [7:0] pr;
    logic [3:0] arc;
    el = 2'($urandom);
    sec = 1'($urandom);
    se = ($urandom % 5) == 0;
    re = ($urandom % 5) == 0;
    pv = 1'($urandom);
    sg = 16'($urandom);
    pr = 8'($urandom);
    arc = 4'($urandom);
    ev = r_main[7] ? pr[r_main[2:0]] : sg[r_main[3:0]];
    inc = (r_rng[3:0] == 4'h0) || |(r_rng[3:0] & arc);
    exc = |(r_rng[19:16] & arc);
    dis = sec && el == 2'h3 && r_main[19];
    dis = dis || (sec && el == 2'h0 && r_main[16]);
    v = ev && started_exp && inc && !exc && !dis;
    // Reset exception takes precedence when both kinds arrive together
    t = re ? (r_main[10] | pv) : (se ? (r_main[11] | pv) : v);
    @(posedge aclk);
    exc_level <= el;
    secure_state <= sec;
    is_syserr_exc <= se;
    is_reset_exc <= re;
    prev_traced <= pv;
    single_resource <= sg;
    pair_resource <= pr;
    arc_match <= arc;
    pchk({14'h0, v, t}, 16'h0003);
  endtask : fstep
  // ******************************
  // Tests
  // ******************************
  initial begin
    void'($urandom(32'h190f_6105));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (offs[i]) axr(offs[i], 32'h0000_0000);
    axw(12'h0fc, 32'hffff_ffff, TIFC_RESP_SLVERR);
    axr(TIFC_OFF_TAG, 32'h0000_0000);
    $display("reset and unmapped test done");
    // Enable goes last so range and start/stop still take all ones
    foreach (offs[i]) begin
      wd = (i == 0) ? 32'hffff_ffaa : 32'hffff_ffff;
      axw(offs[i], wd, TIFC_RESP_OKAY);
      axr(offs[i], wd & msk[i]);
    end
    axw(TIFC_OFF_RANGE, 32'h0000_0000, TIFC_RESP_OKAY);
    axw(TIFC_OFF_SS, 32'h0000_0000, TIFC_RESP_OKAY);
    axw(TIFC_OFF_MAIN, 32'h0000_0000, TIFC_RESP_OKAY);
    axr(TIFC_OFF_RANGE, TIFC_RANGE_MASK);
    axr(TIFC_OFF_SS, TIFC_SS_MASK);
    axr(TIFC_OFF_MAIN, 32'h0000_0000);
    axw(TIFC_OFF_ENABLE, 32'h0000_0000, TIFC_RESP_OKAY);
    axw(TIFC_OFF_SS, 32'h0002_0001, TIFC_RESP_OKAY);
    axr(TIFC_OFF_SS, 32'h0002_0001);
    $display("register access test done");
    foreach (ss_in[i]) begin
      ssp(ss_in[i]);
      axr(TIFC_OFF_MAIN, {22'h0, ss_st[i], 9'h0});
    end
    $display("start stop test done");
    for (int i = 0; i < 6; i++) begin
      tg = 7'(8'h02 + 8'($urandom % 110));
      if (i[0]) tg[0] = 1'h0;
      axw(TIFC_OFF_TAG, {25'($urandom), tg}, TIFC_RESP_OKAY);
      axw(TIFC_OFF_ENABLE, {30'h0, i[0], 1'h0}, TIFC_RESP_OKAY);
      axr(TIFC_OFF_TAG, {25'h0, tg});
      itag = i[0] ? {tg[6:1], 1'h0} : tg;
      pchk({itag, i[0] ? {tg[6:1], 1'h1} : 7'h00, 2'h0}, 16'hfffc);
    end
    $display("stream tag test done");
    for (int k = 0; k < 8; k++) begin
      r_main = $urandom & TIFC_MAIN_MASK;
      r_rng = $urandom & TIFC_RANGE_MASK;
      if (k == 0) r_rng = 32'h0000_0000;
      axw(TIFC_OFF_MAIN, r_main, TIFC_RESP_OKAY);
      axw(TIFC_OFF_RANGE, r_rng, TIFC_RESP_OKAY);
      ssp(k[0] ? 8'h02 : 8'h01);
      started_exp = !k[0];
      repeat (30) fstep();
    end
    repeat (3) @(posedge aclk);
    if (tr_count != 16'h0000) cmp("sink tag", {25'h0, itag}, {25'h0, tr_tag});
    $display("view filter test done");
    wrap_up();
  end
endmodule : tifc_top_tb
`default_nettype wire
